// [core/gmof_pkg.sv]
package gmof_pkg;
  localparam int AXES  = 3;
  localparam int VAL_W = 24;

  localparam logic [7:0] ADDR_CTRL   = 8'h00;
  localparam logic [7:0] ADDR_CMD    = 8'h04;
  localparam logic [7:0] ADDR_STATUS = 8'h08;
  localparam logic [7:0] ADDR_DATA0  = 8'h0C;

  localparam int CTRL_FUNC_LSB    = 0;
  localparam int CTRL_TRANSMIT_TRIGGER_IN_BIT = 2;
  localparam int CTRL_RATE_LSB    = 4;
  localparam logic [1:0] CTRL_FUNC_RESET    = 2'h0;
  localparam logic       CTRL_TRANSMIT_TRIGGER_IN_RESET = 1'b0;
  localparam logic [2:0] CTRL_RATE_RESET    = 3'h0;
  localparam logic [2:0] RATE_LOG2_MAX      = 3'h4;

  localparam int CMD_RESET_BIT     = 0;
  localparam int CMD_SVC_ENTER_BIT = 1;
  localparam int CMD_SVC_NORM_BIT  = 2;
  localparam int CMD_SVC_INIT_BIT  = 3;
  localparam int CMD_SPECIAL_LSB   = 4;

  localparam int STAT_BUSY_BIT    = 0;
  localparam int STAT_STARTUP_BIT = 6;
  localparam int STAT_MODE_LSB    = 8;

  localparam int CLK_FREQ_HZ       = 100_000_000;
  localparam int SAMPLE_RATE_HZ    = 2000;
  localparam int SAMPLE_DIV_CYCLES = CLK_FREQ_HZ / SAMPLE_RATE_HZ;
  localparam int SETTLE_TIME_MS    = 100;
  localparam int STARTUP_TIME_MS   = 1000;
  localparam int SETTLE_TICKS      = SETTLE_TIME_MS * SAMPLE_RATE_HZ / 1000;
  localparam int STARTUP_TICKS     = STARTUP_TIME_MS * SAMPLE_RATE_HZ / 1000;

  // 2^24 * 2^7 / 2000, rate counts to angle counts per internal sample
  localparam logic signed [23:0] INC_SCALE = 24'sh10624E;
  localparam int                 INC_SHIFT = 24;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [6:0] {
    M_SETTLE  = 7'h01,
    M_SYNC    = 7'h02,
    M_PART    = 7'h04,
    M_SERIAL  = 7'h08,
    M_CONFIG  = 7'h10,
    M_NORMAL  = 7'h20,
    M_SERVICE = 7'h40
  } gmof_mode_t;

  typedef enum logic [1:0] {
    FUNC_RATE  = 2'h0,
    FUNC_INCR  = 2'h1,
    FUNC_AVG   = 2'h2,
    FUNC_INTEG = 2'h3
  } gmof_func_t;

  typedef enum logic [1:0] {
    KIND_MEAS   = 2'h0,
    KIND_PART   = 2'h1,
    KIND_SERIAL = 2'h2,
    KIND_CONFIG = 2'h3
  } gmof_kind_t;

  typedef logic signed [VAL_W-1:0] gmof_val_t;

  typedef struct packed {
    logic                  start;
    gmof_kind_t            kind;
    gmof_val_t [AXES-1:0]  value;
  } gmof_tx_t;
endpackage

// [core/gmof_formatter.sv]
// What this block does
// - strobe falls aligned to output sample rate
// - strobe rises after datagram's last bit
// - external trigger: strobe not framing transmission
// - reset pin, reset cmd in normal mode, service init cmd in service mode force initialisation mode
// - settle, sync channels, send three identity datagrams
// - identity datagrams use their own format
// - after third datagram go normal; requestable later
// - sample at 2000/s, send per rate or trigger
// - keep transmitting despite error flags
// - startup flag bit 6 set on normal entry after initialisation
// - service exit to normal skips startup
// - incremental sums scaled samples per output period
// - average is mean of period samples
// - filtered samples are averaged
// - integrated angle wraps silently in [-4,4)
// - rate mode sends newest sample only
// - rate values 24-bit, 2^14 per deg/s
// - angle values 24-bit, 2^21 per degree
// - falling trigger edge sends one newest datagram
`timescale 1ns/10ps
module gmof_formatter #(
  parameter int SAMPLE_DIV    = gmof_pkg::SAMPLE_DIV_CYCLES,
  parameter int SETTLE_TICKS  = gmof_pkg::SETTLE_TICKS,
  parameter int STARTUP_TICKS = gmof_pkg::STARTUP_TICKS
) (
  input  wire logic                   sys_clk,
  input  wire logic                   rst,
  input  wire logic [7:0]             s_axi_awaddr,
  input  wire logic                   s_axi_awvalid,
  output logic                        s_axi_awready,
  input  wire logic [31:0]            s_axi_wdata,
  input  wire logic [3:0]             s_axi_wstrb,
  input  wire logic                   s_axi_wvalid,
  output logic                        s_axi_wready,
  output logic [1:0]                  s_axi_bresp,
  output logic                        s_axi_bvalid,
  input  wire logic                   s_axi_bready,
  input  wire logic [7:0]             s_axi_araddr,
  input  wire logic                   s_axi_arvalid,
  output logic                        s_axi_arready,
  output logic [31:0]                 s_axi_rdata,
  output logic [1:0]                  s_axi_rresp,
  output logic                        s_axi_rvalid,
  input  wire logic                   s_axi_rready,
  input  wire logic                   external_reset_n,
  input  wire logic                   transmit_trigger_in,
  input  wire logic [2:0][23:0]       sampleData,
  input  wire logic                   txDone,
  output logic                        sampleTick,
  output logic                        channelSync,
  output gmof_pkg::gmof_tx_t          txReq,
  output logic                        validity_strobe
);
  localparam int A = gmof_pkg::AXES;

  function automatic logic mapped(input logic [7:0] addr);
    mapped = (addr == gmof_pkg::ADDR_CTRL) || (addr == gmof_pkg::ADDR_CMD) ||
             (addr == gmof_pkg::ADDR_STATUS) ||
             ((addr >= gmof_pkg::ADDR_DATA0) && (addr < gmof_pkg::ADDR_DATA0 + 8'(4 * A)) &&
              (addr[1:0] == 2'h0));
  endfunction

  function automatic logic signed [47:0] scaleSample(input logic signed [23:0] s);
    scaleSample = s * gmof_pkg::INC_SCALE;
  endfunction

  // pin synchronisers
  logic [2:0] rstPinSync;
  logic [2:0] trigSync;
  logic       rstPinLvl;
  logic       trigLvl;
  logic       next_rstPinLvl;
  logic       next_trigLvl;
  logic       pinReset;
  logic       trigFall;

  always_comb begin
    next_rstPinLvl = (rstPinSync[1] == rstPinSync[2]) ? rstPinSync[2] : rstPinLvl;
    next_trigLvl   = (trigSync[1] == trigSync[2]) ? trigSync[2] : trigLvl;
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      rstPinSync <= 3'h7;
      trigSync   <= 3'h7;
      rstPinLvl  <= 1'b1;
      trigLvl    <= 1'b1;
    end else begin
      rstPinSync <= {rstPinSync[1:0], external_reset_n};
      trigSync   <= {trigSync[1:0], transmit_trigger_in};
      rstPinLvl  <= next_rstPinLvl;
      trigLvl    <= next_trigLvl;
    end
  end

  assign pinReset = ~rstPinLvl;
  assign trigFall = trigLvl & ~next_trigLvl;

  // internal sample divider
  logic [31:0] divCnt;
  logic [31:0] next_divCnt;
  logic        next_sampleTick;

  always_comb begin
    next_sampleTick = (divCnt == 32'(SAMPLE_DIV - 1));
    next_divCnt     = next_sampleTick ? 32'h0 : divCnt + 32'h1;
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      divCnt     <= 32'h0;
      sampleTick <= 1'b0;
    end else begin
      divCnt     <= next_divCnt;
      sampleTick <= next_sampleTick;
    end
  end

  // register slave
  gmof_pkg::gmof_func_t ctrlFunc;
  gmof_pkg::gmof_func_t next_ctrlFunc;
  logic        ctrlExt, next_ctrlExt;
  logic [2:0]  ctrlRate, next_ctrlRate;
  logic        awHeld, next_awHeld, wHeld, next_wHeld;
  logic [7:0]  awAddr, next_awAddr;
  logic [31:0] wData, next_wData;
  logic [3:0]  wStrb, next_wStrb;
  logic        next_bvalid, next_rvalid;
  logic [1:0]  next_bresp, next_rresp;
  logic [31:0] next_rdata, rdVal;
  logic [7:0]  wrAddr;
  logic [31:0] wrData;
  logic        wrFire, cmdWr;
  logic        cmdReset, cmdSvcEnter, cmdSvcNorm, cmdSvcInit;
  gmof_pkg::gmof_kind_t specialReq;

  gmof_pkg::gmof_mode_t mode, next_mode;
  logic        startupFlag, next_startupFlag;
  logic [31:0] phaseCnt, next_phaseCnt;
  logic        txBusy, next_txBusy;
  gmof_pkg::gmof_val_t outVal [A];
  gmof_pkg::gmof_val_t next_outVal [A];

  assign s_axi_awready = ~awHeld & ~s_axi_bvalid;
  assign s_axi_wready  = ~wHeld & ~s_axi_bvalid;
  assign s_axi_arready = ~s_axi_rvalid;

  always_comb begin
    wrAddr      = awHeld ? awAddr : s_axi_awaddr;
    wrData      = wHeld ? wData : s_axi_wdata;
    next_wStrb  = wHeld ? wStrb : s_axi_wstrb;
    wrFire      = (awHeld | (s_axi_awvalid & s_axi_awready)) &
                  (wHeld | (s_axi_wvalid & s_axi_wready)) & ~s_axi_bvalid;
    next_awAddr = wrAddr;
    next_wData  = wrData;
    next_awHeld = ~wrFire & (awHeld | (s_axi_awvalid & s_axi_awready));
    next_wHeld  = ~wrFire & (wHeld | (s_axi_wvalid & s_axi_wready));
    next_bvalid = wrFire | (s_axi_bvalid & ~s_axi_bready);
    next_bresp  = s_axi_bresp;
    if (wrFire) begin
      next_bresp = mapped(wrAddr) ? gmof_pkg::RESP_OKAY : gmof_pkg::RESP_SLVERR;
    end
    next_ctrlFunc = ctrlFunc;
    next_ctrlExt  = ctrlExt;
    next_ctrlRate = ctrlRate;
    if (wrFire && wrAddr == gmof_pkg::ADDR_CTRL && next_wStrb[0]) begin
      next_ctrlFunc = gmof_pkg::gmof_func_t'(wrData[gmof_pkg::CTRL_FUNC_LSB +: 2]);
      next_ctrlExt  = wrData[gmof_pkg::CTRL_TRANSMIT_TRIGGER_IN_BIT];
      next_ctrlRate = wrData[gmof_pkg::CTRL_RATE_LSB +: 3];
    end
    cmdWr       = wrFire && wrAddr == gmof_pkg::ADDR_CMD && next_wStrb[0];
    cmdReset    = cmdWr & wrData[gmof_pkg::CMD_RESET_BIT];
    cmdSvcEnter = cmdWr & wrData[gmof_pkg::CMD_SVC_ENTER_BIT];
    cmdSvcNorm  = cmdWr & wrData[gmof_pkg::CMD_SVC_NORM_BIT];
    cmdSvcInit  = cmdWr & wrData[gmof_pkg::CMD_SVC_INIT_BIT];
    specialReq  = cmdWr ? gmof_pkg::gmof_kind_t'(wrData[gmof_pkg::CMD_SPECIAL_LSB +: 2])
                        : gmof_pkg::KIND_MEAS;
    rdVal = 32'h0;
    if (s_axi_araddr == gmof_pkg::ADDR_CTRL) begin
      rdVal[gmof_pkg::CTRL_FUNC_LSB +: 2] = ctrlFunc;
      rdVal[gmof_pkg::CTRL_TRANSMIT_TRIGGER_IN_BIT]   = ctrlExt;
      rdVal[gmof_pkg::CTRL_RATE_LSB +: 3] = ctrlRate;
    end
    if (s_axi_araddr == gmof_pkg::ADDR_STATUS) begin
      rdVal[gmof_pkg::STAT_BUSY_BIT]      = txBusy;
      rdVal[gmof_pkg::STAT_STARTUP_BIT]   = startupFlag;
      rdVal[gmof_pkg::STAT_MODE_LSB +: 7] = mode;
    end
    for (int i = 0; i < A; i++) begin
      if (s_axi_araddr == gmof_pkg::ADDR_DATA0 + 8'(4 * i)) begin
        rdVal[23:0] = outVal[i];
      end
    end
    next_rvalid = s_axi_arready & s_axi_arvalid | (s_axi_rvalid & ~s_axi_rready);
    next_rdata  = s_axi_rdata;
    next_rresp  = s_axi_rresp;
    if (s_axi_arready & s_axi_arvalid) begin
      next_rdata = rdVal;
      next_rresp = mapped(s_axi_araddr) ? gmof_pkg::RESP_OKAY : gmof_pkg::RESP_SLVERR;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      awHeld       <= 1'b0;
      wHeld        <= 1'b0;
      awAddr       <= 8'h00;
      wData        <= 32'h0;
      wStrb        <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= gmof_pkg::RESP_OKAY;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0;
      s_axi_rresp  <= gmof_pkg::RESP_OKAY;
      ctrlFunc     <= gmof_pkg::gmof_func_t'(gmof_pkg::CTRL_FUNC_RESET);
      ctrlExt      <= gmof_pkg::CTRL_TRANSMIT_TRIGGER_IN_RESET;
      ctrlRate     <= gmof_pkg::CTRL_RATE_RESET;
    end else begin
      awHeld       <= next_awHeld;
      wHeld        <= next_wHeld;
      awAddr       <= next_awAddr;
      wData        <= next_wData;
      wStrb        <= next_wStrb;
      s_axi_bvalid <= next_bvalid;
      s_axi_bresp  <= next_bresp;
      s_axi_rvalid <= next_rvalid;
      s_axi_rdata  <= next_rdata;
      s_axi_rresp  <= next_rresp;
      ctrlFunc     <= next_ctrlFunc;
      ctrlExt      <= next_ctrlExt;
      ctrlRate     <= next_ctrlRate;
    end
  end

  // operating mode sequencer
  logic initReq;

  always_comb begin
    initReq = pinReset | (cmdReset & (mode == gmof_pkg::M_NORMAL)) |
              (cmdSvcInit & (mode == gmof_pkg::M_SERVICE));
    next_mode        = mode;
    next_phaseCnt    = phaseCnt;
    next_startupFlag = startupFlag;
    if (initReq) begin
      next_mode        = gmof_pkg::M_SETTLE;
      next_phaseCnt    = 32'h0;
      next_startupFlag = 1'b0;
    end else begin
      unique case (mode)
        gmof_pkg::M_SETTLE: begin
          if (sampleTick) begin
            if (phaseCnt == 32'(SETTLE_TICKS - 1)) begin
              next_mode     = gmof_pkg::M_SYNC;
              next_phaseCnt = 32'h0;
            end else begin
              next_phaseCnt = phaseCnt + 32'h1;
            end
          end
        end
        gmof_pkg::M_SYNC: next_mode = gmof_pkg::M_PART;
        gmof_pkg::M_PART: begin
          if (txDone && txReq.kind == gmof_pkg::KIND_PART) begin
            next_mode = gmof_pkg::M_SERIAL;
          end
        end
        gmof_pkg::M_SERIAL: begin
          if (txDone && txReq.kind == gmof_pkg::KIND_SERIAL) begin
            next_mode = gmof_pkg::M_CONFIG;
          end
        end
        gmof_pkg::M_CONFIG: begin
          if (txDone && txReq.kind == gmof_pkg::KIND_CONFIG) begin
            next_mode        = gmof_pkg::M_NORMAL;
            next_startupFlag = 1'b1;
            next_phaseCnt    = 32'h0;
          end
        end
        gmof_pkg::M_NORMAL: begin
          if (startupFlag && sampleTick) begin
            if (phaseCnt == 32'(STARTUP_TICKS - 1)) begin
              next_startupFlag = 1'b0;
            end else begin
              next_phaseCnt = phaseCnt + 32'h1;
            end
          end
          if (cmdSvcEnter) begin
            next_mode = gmof_pkg::M_SERVICE;
          end
        end
        gmof_pkg::M_SERVICE: begin
          if (cmdSvcNorm) begin
            next_mode        = gmof_pkg::M_NORMAL;
            next_startupFlag = 1'b0;
          end
        end
        default: next_mode = gmof_pkg::M_SETTLE;
      endcase
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      mode        <= gmof_pkg::M_SETTLE;
      phaseCnt    <= 32'h0;
      startupFlag <= 1'b0;
    end else begin
      mode        <= next_mode;
      phaseCnt    <= next_phaseCnt;
      startupFlag <= next_startupFlag;
    end
  end

  assign channelSync = (mode == gmof_pkg::M_SYNC);

  // output functions
  logic [2:0] rateLog2, effLog2;
  logic [4:0] nSamp;
  logic [3:0] outCnt, next_outCnt;
  logic       outTick;
  logic signed [27:0] sumAcc [A];
  logic signed [27:0] next_sumAcc [A];
  logic signed [47:0] incAcc [A];
  logic signed [47:0] next_incAcc [A];
  logic signed [47:0] intAcc [A];
  logic signed [47:0] next_intAcc [A];

  always_comb begin
    rateLog2 = (ctrlRate > gmof_pkg::RATE_LOG2_MAX) ? gmof_pkg::RATE_LOG2_MAX : ctrlRate;
    effLog2  = ctrlExt ? 3'h0 : rateLog2;
    nSamp    = 5'h1 << effLog2;
    outTick  = sampleTick && ({1'b0, outCnt} == nSamp - 5'h1);
    next_outCnt = outCnt;
    if (sampleTick) begin
      next_outCnt = outTick ? 4'h0 : outCnt + 4'h1;
    end
    if (initReq) begin
      next_outCnt = 4'h0;
    end
  end

  always_comb begin
    logic signed [23:0] sIn;
    logic signed [47:0] prod;
    logic signed [27:0] sumIn;
    logic signed [47:0] incIn;
    sIn   = 24'sh0;
    prod  = 48'sh0;
    sumIn = 28'sh0;
    incIn = 48'sh0;
    for (int i = 0; i < A; i++) begin
      sIn            = $signed(sampleData[i]);
      prod           = scaleSample(sIn);
      sumIn          = sumAcc[i] + 28'(sIn);
      incIn          = incAcc[i] + prod;
      next_sumAcc[i] = sumAcc[i];
      next_incAcc[i] = incAcc[i];
      next_intAcc[i] = intAcc[i];
      next_outVal[i] = outVal[i];
      if (sampleTick) begin
        next_intAcc[i] = intAcc[i] + prod;
        next_sumAcc[i] = sumIn;
        next_incAcc[i] = incIn;
        if (outTick) begin
          next_sumAcc[i] = 28'sh0;
          next_incAcc[i] = 48'sh0;
          unique case (ctrlFunc)
            gmof_pkg::FUNC_RATE:  next_outVal[i] = sIn;
            gmof_pkg::FUNC_INCR:  next_outVal[i] = incIn[47:24];
            gmof_pkg::FUNC_AVG:   next_outVal[i] = 24'(sumIn >>> effLog2);
            gmof_pkg::FUNC_INTEG: next_outVal[i] = next_intAcc[i][47:24];
          endcase
        end
      end
      if (initReq) begin
        next_intAcc[i] = 48'sh0;
        next_sumAcc[i] = 28'sh0;
        next_incAcc[i] = 48'sh0;
      end
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      outCnt <= 4'h0;
      for (int i = 0; i < A; i++) begin
        sumAcc[i] <= 28'sh0;
        incAcc[i] <= 48'sh0;
        intAcc[i] <= 48'sh0;
        outVal[i] <= 24'sh0;
      end
    end else begin
      outCnt <= next_outCnt;
      for (int i = 0; i < A; i++) begin
        sumAcc[i] <= next_sumAcc[i];
        incAcc[i] <= next_incAcc[i];
        intAcc[i] <= next_intAcc[i];
        outVal[i] <= next_outVal[i];
      end
    end
  end

  // datagram launch and validity strobe
  gmof_pkg::gmof_tx_t   next_txReq;
  gmof_pkg::gmof_kind_t pend, next_pend;
  logic launch, specialMode, next_strobe;

  always_comb begin
    launch      = ctrlExt ? trigFall : outTick;
    specialMode = (mode == gmof_pkg::M_PART) || (mode == gmof_pkg::M_SERIAL) ||
                  (mode == gmof_pkg::M_CONFIG);
    next_txReq       = txReq;
    next_txReq.start = 1'b0;
    next_txBusy      = txBusy & ~txDone;
    next_pend        = pend;
    if (specialMode && !txBusy) begin
      next_txReq.start = 1'b1;
      next_txReq.value = '0;
      next_txBusy      = 1'b1;
      next_txReq.kind  = (mode == gmof_pkg::M_PART) ? gmof_pkg::KIND_PART :
                         (mode == gmof_pkg::M_SERIAL) ? gmof_pkg::KIND_SERIAL :
                         gmof_pkg::KIND_CONFIG;
    end else if (mode == gmof_pkg::M_NORMAL && launch && !txBusy) begin
      next_txReq.start = 1'b1;
      next_txReq.kind  = pend;
      next_txBusy      = 1'b1;
      next_pend        = gmof_pkg::KIND_MEAS;
      for (int i = 0; i < A; i++) begin
        next_txReq.value[i] = (pend == gmof_pkg::KIND_MEAS) ? next_outVal[i] : 24'sh0;
      end
    end
    if (mode == gmof_pkg::M_NORMAL && specialReq != gmof_pkg::KIND_MEAS) begin
      next_pend = specialReq;
    end
    if (initReq) begin
      next_pend = gmof_pkg::KIND_MEAS;
    end
    next_strobe = validity_strobe;
    if (mode == gmof_pkg::M_NORMAL && ctrlExt) begin
      next_strobe = ~sampleTick;
    end else if (mode == gmof_pkg::M_NORMAL && launch && !txBusy) begin
      next_strobe = 1'b0;
    end else if (txDone || (!txBusy && mode != gmof_pkg::M_NORMAL)) begin
      next_strobe = 1'b1;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      txReq           <= '0;
      txBusy          <= 1'b0;
      pend            <= gmof_pkg::KIND_MEAS;
      validity_strobe <= 1'b1;
    end else begin
      txReq           <= next_txReq;
      txBusy          <= next_txBusy;
      pend            <= next_pend;
      validity_strobe <= next_strobe;
    end
  end

  // checks
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  property p_strobeFall;
    (mode == gmof_pkg::M_NORMAL && !ctrlExt && outTick && !txBusy) |=> !validity_strobe;
  endproperty
  a_strobeFall: assert property (p_strobeFall) else $error("strobe did not fall");

  property p_strobeRise;
    (txDone && txBusy && mode == gmof_pkg::M_NORMAL && !ctrlExt) |=> validity_strobe;
  endproperty
  a_strobeRise: assert property (p_strobeRise) else $error("strobe did not rise");

  property p_extStrobe;
    (mode == gmof_pkg::M_NORMAL && ctrlExt && !sampleTick) |=> validity_strobe;
  endproperty
  a_extStrobe: assert property (p_extStrobe) else $error("strobe framed a datagram");

  property p_initEntry;
    pinReset |=> (mode == gmof_pkg::M_SETTLE) && !startupFlag;
  endproperty
  a_initEntry: assert property (p_initEntry) else $error("reset pin missed");

  property p_partThenSerial;
    (mode == gmof_pkg::M_PART && txDone && txReq.kind == gmof_pkg::KIND_PART && !initReq)
      |=> (mode == gmof_pkg::M_SERIAL) ##1 (txReq.start && txReq.kind == gmof_pkg::KIND_SERIAL);
  endproperty
  a_partThenSerial: assert property (p_partThenSerial) else $error("bad order");

  property p_specialKind;
    (txReq.start && mode inside {gmof_pkg::M_PART, gmof_pkg::M_SERIAL, gmof_pkg::M_CONFIG})
      |-> txReq.kind != gmof_pkg::KIND_MEAS;
  endproperty
  a_specialKind: assert property (p_specialKind) else $error("special sent as data");

  property p_configDone;
    (mode == gmof_pkg::M_CONFIG && txDone && txReq.kind == gmof_pkg::KIND_CONFIG && !initReq)
      |=> (mode == gmof_pkg::M_NORMAL) && startupFlag;
  endproperty
  a_configDone: assert property (p_configDone) else $error("no normal entry");

  property p_svcExit;
    (mode == gmof_pkg::M_SERVICE && cmdSvcNorm && !initReq)
      |=> (mode == gmof_pkg::M_NORMAL) && !startupFlag;
  endproperty
  a_svcExit: assert property (p_svcExit) else $error("startup after service");

  property p_rateOnly;
    (outTick && ctrlFunc == gmof_pkg::FUNC_RATE) |=> outVal[0] == $past(sampleData[0]);
  endproperty
  a_rateOnly: assert property (p_rateOnly) else $error("rate not newest");

  property p_integClear;
    initReq |=> (intAcc[0] == 48'sh0) && (intAcc[A-1] == 48'sh0);
  endproperty
  a_integClear: assert property (p_integClear) else $error("angle not cleared");

  property p_trigLaunch;
    (mode == gmof_pkg::M_NORMAL && ctrlExt && trigFall && !txBusy) |=> txReq.start && txBusy;
  endproperty
  a_trigLaunch: assert property (p_trigLaunch) else $error("trigger ignored");

  c_normalReached: cover property (mode == gmof_pkg::M_CONFIG ##1 mode == gmof_pkg::M_NORMAL);
  c_trigSend: cover property (ctrlExt && trigFall ##1 txReq.start);
  c_svcReturn: cover property (mode == gmof_pkg::M_SERVICE ##1 mode == gmof_pkg::M_NORMAL);
endmodule

// [test/gmof_tx_model.sv]
`timescale 1ns/10ps
module gmof_tx_model (
  input  wire logic               sys_clk,
  input  wire logic               rst,
  input  wire logic               slowTx,
  input  wire gmof_pkg::gmof_tx_t txReq,
  output logic                    txDone
);
  logic [4:0] busyCount;
  // one done pulse per start, after a short or long send
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      busyCount <= 5'h00;
      txDone    <= 1'b0;
    end else begin
      txDone <= (busyCount == 5'h01);
      if (txReq.start) begin
        busyCount <= slowTx ? 5'h0F : 5'h03;
      end else if (busyCount != 5'h00) begin
        busyCount <= busyCount - 5'h01;
      end
    end
  end
endmodule

// [test/gmof_formatter_test.sv]
`timescale 1ns/10ps
module gmof_formatter_test;
  logic sys_clk = 1'b0, rst = 1'b1, slowTx = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
  logic s_axi_rready = 0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, txDone, sampleTick, channelSync, validity_strobe;
  logic external_reset_n = 1'b1, transmit_trigger_in = 1'b1;
  logic [1:0] s_axi_bresp, s_axi_rresp, rr;
  logic [2:0][23:0] sampleData = {24'h7FFFFF, 24'h800000, 24'h000123};
  gmof_pkg::gmof_tx_t txReq, t;
  int miscompares = 0, checksDone = 0;
  gmof_formatter #(.SAMPLE_DIV(20), .SETTLE_TICKS(2), .STARTUP_TICKS(3)) gmof_formatter_inst (
    .sys_clk, .rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .external_reset_n, .transmit_trigger_in, .sampleData, .txDone, .sampleTick, .channelSync,
    .txReq, .validity_strobe);
  gmof_tx_model gmof_tx_model_inst (.sys_clk, .rst, .slowTx, .txReq, .txDone);
  always #5 sys_clk = ~sys_clk;
  task automatic chk(input logic [71:0] got, input logic [71:0] exp);
    checksDone++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic axiWr(input logic [7:0] a, input logic [31:0] d);
    logic aw, w, b;
    @(posedge sys_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(negedge sys_clk);
      aw = s_axi_awready;
      w = s_axi_wready;
      b = s_axi_bvalid;
      @(posedge sys_clk);
      if (aw) s_axi_awvalid <= 1'b0;
      if (w) s_axi_wvalid <= 1'b0;
    end while (!b);
    s_axi_bready <= 1'b0;
  endtask
  task automatic axiRd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    logic ar, v;
    @(posedge sys_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(negedge sys_clk);
      ar = s_axi_arready;
      v = s_axi_rvalid;
      d = s_axi_rdata;
      r = s_axi_rresp;
      @(posedge sys_clk);
      if (ar) s_axi_arvalid <= 1'b0;
    end while (!v);
    s_axi_rready <= 1'b0;
  endtask
  task automatic waitStart(input int k);
    int n;
    repeat (k) begin
      n = 0;
      do begin
        @(negedge sys_clk);
        n++;
      end while (txReq.start !== 1'b1 && n < 400);
    end
    t = txReq;
  endtask
  task automatic end_of_test;
    if (miscompares == 0 && checksDone > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    repeat (10) @(posedge sys_clk);
    rst <= 1'b0;
    for (int i = 1; i < 4; i++) begin
      waitStart(1);
      chk(t.kind, 72'(i));
      chk(t.value, 72'h0);
    end
    repeat (20) @(posedge sys_clk);
    axiRd(gmof_pkg::ADDR_STATUS, rd, rr);
    chk(rd[14:6], 9'h081);
    waitStart(1);
    chk(t.value, sampleData);
    chk(validity_strobe, 1'b0);
    do @(negedge sys_clk); while (txDone !== 1'b1);
    chk(validity_strobe, 1'b0);
    @(negedge sys_clk);
    chk(validity_strobe, 1'b1);
    repeat (60) @(posedge sys_clk);
    axiRd(gmof_pkg::ADDR_STATUS, rd, rr);
    chk(rd[14:6], 9'h080);
    slowTx <= 1'b1;
    sampleData <= {3{24'h0007D0}};
    axiWr(gmof_pkg::ADDR_CTRL, 32'h11);
    waitStart(3);
    chk(t.value, {3{24'h000100}});
    axiWr(gmof_pkg::ADDR_CTRL, 32'h12);
    waitStart(3);
    chk(t.value, {3{24'h0007D0}});
    axiWr(gmof_pkg::ADDR_CTRL, 32'h04);
    do @(negedge sys_clk); while (sampleTick !== 1'b1);
    @(negedge sys_clk);
    chk(validity_strobe, 1'b0);
    @(negedge sys_clk);
    chk(validity_strobe, 1'b1);
    @(posedge sys_clk);
    transmit_trigger_in <= 1'b0;
    waitStart(1);
    chk(t.kind, 72'(gmof_pkg::KIND_MEAS));
    chk(t.value, {3{24'h0007D0}});
    @(posedge sys_clk);
    transmit_trigger_in <= 1'b1;
    repeat (20) @(posedge sys_clk);
    axiWr(gmof_pkg::ADDR_CMD, 32'h20);
    transmit_trigger_in <= 1'b0;
    waitStart(1);
    chk(t.kind, 72'(gmof_pkg::KIND_SERIAL));
    chk(t.value, 72'h0);
    @(posedge sys_clk);
    transmit_trigger_in <= 1'b1;
    external_reset_n <= 1'b0;
    repeat (8) @(posedge sys_clk);
    axiRd(gmof_pkg::ADDR_STATUS, rd, rr);
    chk(rd[14:6], 9'h004);
    external_reset_n <= 1'b1;
    do @(negedge sys_clk); while (channelSync !== 1'b1);
    waitStart(1);
    chk(t.kind, 72'(gmof_pkg::KIND_PART));
    waitStart(2);
    chk(t.kind, 72'(gmof_pkg::KIND_CONFIG));
    repeat (30) @(posedge sys_clk);
    axiWr(gmof_pkg::ADDR_CMD, 32'h02);
    axiWr(gmof_pkg::ADDR_CMD, 32'h04);
    axiRd(gmof_pkg::ADDR_STATUS, rd, rr);
    chk(rd[14:6], 9'h080);
    axiWr(gmof_pkg::ADDR_CMD, 32'h01);
    axiRd(gmof_pkg::ADDR_STATUS, rd, rr);
    chk(rd[14:6], 9'h004);
    axiRd(8'h40, rd, rr);
    chk({rr, rd}, {gmof_pkg::RESP_SLVERR, 32'h0});
    end_of_test();
  end
  initial begin
    repeat (20000) @(posedge sys_clk);
    miscompares++;
    end_of_test();
  end
endmodule
